// ==== common/add_sub_pkg.sv ====
// constants, codes and state layout of the add/subtract sequencer
// assumes a single 40 MHz phase clock and a 16-entry private memory
package add_sub_pkg;

   // ----------------------------------------------------------------
   // widths and clock
   // ----------------------------------------------------------------
   localparam int WORD_W        = 32;
   localparam int REG_AW        = 4;
   localparam int REG_DEPTH     = 16;
   localparam int ADDR_W        = 17;
   localparam int BUS_AW        = 5;
   localparam int CLK_PERIOD_NS = 25;

   // ----------------------------------------------------------------
   // opcodes, indirect bit ignored by the decode
   // ----------------------------------------------------------------
   localparam logic [6:0] OPC_ADD_WORD  = 7'h30;
   localparam logic [6:0] OPC_SUB_WORD  = 7'h38;
   localparam logic [6:0] OPC_ADD_DWORD = 7'h10;
   localparam logic [6:0] OPC_SUB_DWORD = 7'h18;

   // overflow trap location
   localparam logic [7:0] TRAP_VECTOR   = 8'h43;

   // ----------------------------------------------------------------
   // register map, word addresses
   // ----------------------------------------------------------------
   localparam logic [BUS_AW-1:0] ADDR_PM_LAST = 5'h0f;
   localparam logic [BUS_AW-1:0] ADDR_STATUS  = 5'h10;
   localparam logic [BUS_AW-1:0] ADDR_CONTROL = 5'h11;
   localparam int  CTRL_MASK_BIT   = 0;
   localparam logic CTRL_MASK_RESET = 1'b0;
   localparam int  STAT_BUSY_BIT   = 4;
   localparam int  STAT_WAIT_BIT   = 5;
   localparam int  STAT_TRAP_BIT   = 6;

   // condition code bit positions, low two give 00/10/01
   localparam int CC_CARRY_BIT = 3;
   localparam int CC_OVF_BIT   = 2;
   localparam int CC_POS_BIT   = 1;
   localparam int CC_NEG_BIT   = 0;
   localparam logic [3:0] CC_RESET = 4'h0;

   // ----------------------------------------------------------------
   // sequencer phases and state
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE        = 3'b000,
      ST_PREPARE     = 3'b001,
      ST_FIRST_EXEC  = 3'b010,
      ST_SECOND_EXEC = 3'b011,
      ST_THIRD_EXEC  = 3'b100,
      ST_RESTORE     = 3'b101
   } phase_t;

   typedef struct packed {
      phase_t              ph;
      logic                dword;
      logic                sub;
      logic [REG_AW-1:0]   rsel;
      logic [WORD_W-1:0]   a;
      logic [WORD_W-1:0]   c;
      logic [WORD_W-1:0]   d;
      logic [ADDR_W-1:0]   b;
      logic [ADDR_W-1:0]   p;
      logic [WORD_W-1:0]   old_lo;
      logic [WORD_W-1:0]   sum;
      logic                adder_plus_preset;
      logic                adder_minus_preset;
      logic                core_request_ff;
      logic                data_wait_ff;
      logic                request_delay_ff;
      logic                rw;
      logic                odd_reg_force_ff;
      logic                b_to_sum_preset;
      logic                hi_reg_to_a_preset;
      logic                low_word_nonzero_ff;
      logic                carry_hold_ff;
      logic                carry_in_ff;
      logic [3:0]          cc;
      logic                trap_req;
      logic                trap_seen;
      logic                done;
      logic                busy;
      logic                long_clock_period;
      logic                mask;
      logic                rdsel;
      logic [WORD_W-1:0]   rd_hold;
   } seq_state_t;

endpackage

// ==== common/pm_if.sv ====
// carrier between the sequencer and the private memory array
// assumes one write port and two registered read ports
`timescale 1ns/100ps
interface pm_if #(
   parameter int AW = 4,
   parameter int DW = 32
);
   logic          we;
   logic [AW-1:0] waddr;
   logic [DW-1:0] wdata;
   logic          re_a;
   logic [AW-1:0] raddr_a;
   logic [DW-1:0] rdata_a;
   logic          re_b;
   logic [AW-1:0] raddr_b;
   logic [DW-1:0] rdata_b;

   modport core (
      output we, waddr, wdata, re_a, raddr_a, re_b, raddr_b,
      input  rdata_a, rdata_b
   );
   modport mem (
      input  we, waddr, wdata, re_a, raddr_a, re_b, raddr_b,
      output rdata_a, rdata_b
   );
endinterface

// ==== src/add_sub_exec.sv ====
// execution sequencer and adder for word and doubleword add/subtract
// assumes operands of the generic preparation arrive with start
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/100ps
module add_sub_exec
   import add_sub_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   input  wire logic              start,
   input  wire logic [7:0]        opcode,
   input  wire logic [REG_AW-1:0] reg_field,
   input  wire logic [WORD_W-1:0] eff_word,
   input  wire logic [ADDR_W-1:0] hi_word_addr,
   input  wire logic [ADDR_W-1:0] next_pc,
   input  wire logic [WORD_W-1:0] mem_data,
   input  wire logic              mem_release,
   input  wire logic [BUS_AW-1:0] bus_addr,
   input  wire logic [WORD_W-1:0] bus_wdata,
   input  wire logic              bus_wr,
   input  wire logic              bus_rd,
   output logic      [WORD_W-1:0] bus_rdata,
   output logic                   busy,
   output logic                   done,
   output logic                   core_req,
   output logic      [ADDR_W-1:0] core_addr,
   output logic                   data_wait,
   output logic      [WORD_W-1:0] sum_bus,
   output logic      [3:0]        cond_code,
   output logic                   trap_req,
   output logic      [7:0]        trap_vector,
   output logic                   long_clock_period
);

   seq_state_t            st_ff;
   seq_state_t            nxt_st;
   logic [WORD_W-1:0]     dd;
   logic                  cin;
   logic [WORD_W:0]       add_res;
   logic [WORD_W-1:0]     res;
   logic                  ovf;
   logic                  trap;
   logic [6:0]            opc;
   logic                  op_word;
   logic                  op_dword;
   logic                  op_sub;
   logic                  pm_hit;

   pm_if #(.AW(REG_AW), .DW(WORD_W)) pm ();

   pm_regs #(.DEPTH(REG_DEPTH)) u_regs (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .pm      (pm)
   );

   // ----------------------------------------------------------------
   // condition codes from a finished result
   // ----------------------------------------------------------------
   function automatic logic [3:0] codes(input logic carry,
                                        input logic over,
                                        input logic nonzero,
                                        input logic negative);
      logic [3:0] cc;
      cc               = CC_RESET;
      cc[CC_CARRY_BIT] = carry;
      cc[CC_OVF_BIT]   = over;
      cc[CC_POS_BIT]   = nonzero && !negative;
      cc[CC_NEG_BIT]   = negative;
      return cc;
   endfunction

   // ----------------------------------------------------------------
   // opcode decode, indirect bit dropped
   // ----------------------------------------------------------------
   assign opc      = opcode[6:0];
   assign op_word  = (opc == OPC_ADD_WORD) || (opc == OPC_SUB_WORD);
   assign op_dword = (opc == OPC_ADD_DWORD) || (opc == OPC_SUB_DWORD);
   assign op_sub   = (opc == OPC_SUB_WORD) || (opc == OPC_SUB_DWORD);
   assign pm_hit   = (bus_addr <= ADDR_PM_LAST);

   // ----------------------------------------------------------------
   // adder: subtract as a + ~d + carry
   // ----------------------------------------------------------------
   always_comb begin
      dd      = st_ff.sub ? ~st_ff.d : st_ff.d;
      // low word starts with the subtract one, high word with the hold
      cin     = (st_ff.ph == ST_THIRD_EXEC) ? st_ff.carry_in_ff
                                            : st_ff.sub;
      add_res = {1'b0, st_ff.a} + {1'b0, dd} + {{WORD_W{1'b0}}, cin};
      res     = add_res[WORD_W-1:0];
      ovf     = (st_ff.a[WORD_W-1] == dd[WORD_W-1]) &&
                (res[WORD_W-1] != st_ff.a[WORD_W-1]);
      trap    = ovf && st_ff.mask;
   end

   // ----------------------------------------------------------------
   // sequencer, private memory ports and register bus
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st          = st_ff;
      nxt_st.done     = 1'b0;
      nxt_st.trap_req = 1'b0;
      pm.we           = 1'b0;
      pm.waddr        = st_ff.rsel;
      pm.wdata        = res;
      pm.re_a         = 1'b0;
      pm.raddr_a      = st_ff.rsel;
      pm.re_b         = 1'b0;
      pm.raddr_b      = bus_addr[REG_AW-1:0];

      // release retires the request; later sets below win
      if (mem_release) begin
         nxt_st.core_request_ff = 1'b0;
         nxt_st.data_wait_ff    = 1'b0;
      end
      // delay flop cleared one clock ago raises the wait flag now
      if (!st_ff.request_delay_ff) begin
         nxt_st.data_wait_ff     = 1'b1;
         nxt_st.request_delay_ff = 1'b1;
      end

      unique case (st_ff.ph)
         ST_IDLE: begin
            // start while the wait flag stands would lose a clock
            if (start && !st_ff.data_wait_ff && (op_word || op_dword)) begin
               nxt_st.ph    = ST_PREPARE;
               nxt_st.dword = op_dword;
               nxt_st.sub   = op_sub;
               nxt_st.rsel  = reg_field;
               nxt_st.c     = eff_word;
               nxt_st.d     = eff_word;
               nxt_st.p     = op_dword ? hi_word_addr : next_pc;
               nxt_st.b     = next_pc;
               pm.re_a      = 1'b1;
               // doubleword reads the odd partner first
               pm.raddr_a   = op_dword ? {reg_field[REG_AW-1:1], 1'b1}
                                       : reg_field;
            end
         end
         ST_PREPARE: begin
            nxt_st.a                  = pm.rdata_a;
            nxt_st.old_lo             = pm.rdata_a;
            nxt_st.adder_plus_preset  = !st_ff.sub;
            nxt_st.adder_minus_preset = st_ff.sub;
            nxt_st.core_request_ff    = 1'b1;
            nxt_st.rw                 = 1'b1;
            if (st_ff.dword) begin
               nxt_st.request_delay_ff = 1'b0;
               nxt_st.odd_reg_force_ff = 1'b1;
            end
            nxt_st.ph = ST_FIRST_EXEC;
         end
         ST_FIRST_EXEC: begin
            nxt_st.sum                = res;
            nxt_st.adder_plus_preset  = 1'b0;
            nxt_st.adder_minus_preset = 1'b0;
            nxt_st.rw                 = 1'b0;
            nxt_st.odd_reg_force_ff   = 1'b0;
            pm.waddr = {st_ff.rsel[REG_AW-1:1],
                        st_ff.rsel[0] | st_ff.odd_reg_force_ff};
            if (!st_ff.dword) begin
               // a trapped result never reaches the register
               pm.we           = st_ff.rw && !trap;
               nxt_st.cc       = codes(add_res[WORD_W], ovf,
                                       res != '0,
                                       res[WORD_W-1]);
               nxt_st.trap_req = trap;
               nxt_st.done     = 1'b1;
               nxt_st.ph       = ST_IDLE;
            end else begin
               pm.we                      = st_ff.rw;
               nxt_st.low_word_nonzero_ff = (res != '0);
               nxt_st.carry_hold_ff       = add_res[WORD_W];
               nxt_st.b_to_sum_preset     = 1'b1;
               nxt_st.hi_reg_to_a_preset  = 1'b1;
               pm.re_a                    = 1'b1;
               pm.raddr_a                 = st_ff.rsel;
               nxt_st.ph                  = ST_SECOND_EXEC;
            end
         end
         ST_SECOND_EXEC: begin
            // no phase clock until core memory releases the word
            if (!st_ff.data_wait_ff || mem_release) begin
               if (st_ff.b_to_sum_preset) begin
                  nxt_st.sum = {{(WORD_W-ADDR_W){1'b0}}, st_ff.b};
                  nxt_st.p   = st_ff.b;
               end
               if (st_ff.hi_reg_to_a_preset)
                  nxt_st.a = pm.rdata_a;
               nxt_st.c                  = mem_data;
               nxt_st.d                  = mem_data;
               nxt_st.b_to_sum_preset    = 1'b0;
               nxt_st.hi_reg_to_a_preset = 1'b0;
               nxt_st.adder_plus_preset  = !st_ff.sub;
               nxt_st.adder_minus_preset = st_ff.sub;
               nxt_st.core_request_ff    = 1'b1;
               nxt_st.request_delay_ff   = 1'b0;
               nxt_st.rw                 = 1'b1;
               nxt_st.carry_in_ff        = st_ff.carry_hold_ff;
               nxt_st.ph                 = ST_THIRD_EXEC;
            end
         end
         ST_THIRD_EXEC: begin
            nxt_st.sum                = res;
            nxt_st.adder_plus_preset  = 1'b0;
            nxt_st.adder_minus_preset = 1'b0;
            nxt_st.rw                 = 1'b0;
            pm.we                     = st_ff.rw && !trap;
            nxt_st.cc = codes(add_res[WORD_W], ovf,
                              st_ff.low_word_nonzero_ff || (res != '0),
                              res[WORD_W-1]);
            nxt_st.trap_req = trap;
            nxt_st.done     = !trap;
            nxt_st.ph       = trap ? ST_RESTORE : ST_IDLE;
         end
         ST_RESTORE: begin
            // low word went out already; put the old one back, but
            // only once the pending core word has been released
            pm.waddr = {st_ff.rsel[REG_AW-1:1], 1'b1};
            pm.wdata = st_ff.old_lo;
            if (!st_ff.data_wait_ff || mem_release) begin
               pm.we       = 1'b1;
               nxt_st.done = 1'b1;
               nxt_st.ph   = ST_IDLE;
            end
         end
         default: begin
            nxt_st.ph = ST_IDLE;
         end
      endcase

      if (nxt_st.trap_req)
         nxt_st.trap_seen = 1'b1;

      // long period whenever an exec phase writes a register
      nxt_st.long_clock_period = nxt_st.rw &&
         ((nxt_st.ph == ST_FIRST_EXEC) ||
          (nxt_st.ph == ST_THIRD_EXEC));
      nxt_st.busy = (nxt_st.ph != ST_IDLE) || nxt_st.data_wait_ff;

      // bus writes lose to a sequencer write in the same cycle
      if (bus_wr && pm_hit && !pm.we) begin
         pm.we    = 1'b1;
         pm.waddr = bus_addr[REG_AW-1:0];
         pm.wdata = bus_wdata;
      end
      if (bus_wr && (bus_addr == ADDR_CONTROL))
         nxt_st.mask = bus_wdata[CTRL_MASK_BIT];
      if (bus_wr && (bus_addr == ADDR_STATUS) &&
          bus_wdata[STAT_TRAP_BIT] && !nxt_st.trap_req)
         nxt_st.trap_seen = 1'b0;

      // read answers: memory word or a held status/control word
      if (bus_rd) begin
         pm.re_b        = pm_hit;
         nxt_st.rdsel   = pm_hit;
         nxt_st.rd_hold = '0;
         if (bus_addr == ADDR_STATUS) begin
            nxt_st.rd_hold[3:0]          = st_ff.cc;
            nxt_st.rd_hold[STAT_BUSY_BIT] = st_ff.busy;
            nxt_st.rd_hold[STAT_WAIT_BIT] = st_ff.data_wait_ff;
            nxt_st.rd_hold[STAT_TRAP_BIT] = st_ff.trap_seen;
         end
         if (bus_addr == ADDR_CONTROL)
            nxt_st.rd_hold[CTRL_MASK_BIT] = st_ff.mask;
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff                  <= '0;
         st_ff.ph               <= ST_IDLE;
         st_ff.request_delay_ff <= 1'b1;
         st_ff.cc               <= CC_RESET;
         st_ff.mask             <= CTRL_MASK_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // outputs straight off the state register, except trap_vector, which is the constant TRAP_VECTOR
   assign busy              = st_ff.busy;
   assign done              = st_ff.done;
   assign core_req          = st_ff.core_request_ff;
   assign core_addr         = st_ff.p;
   assign data_wait         = st_ff.data_wait_ff;
   assign sum_bus           = st_ff.sum;
   assign cond_code         = st_ff.cc;
   assign trap_req          = st_ff.trap_req;
   assign trap_vector       = TRAP_VECTOR;
   assign long_clock_period = st_ff.long_clock_period;
   // memory words come from the array's read register
   assign bus_rdata         = st_ff.rdsel ? pm.rdata_b : st_ff.rd_hold;

endmodule

// ==== src/pm_regs.sv ====
// private memory register array, registered read data
// assumes the sequencer never reads and writes one entry in one cycle
`timescale 1ns/100ps
module pm_regs
   import add_sub_pkg::*;
#(
   parameter int DEPTH = REG_DEPTH
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   pm_if.mem        pm
);

   // refuse, at elaboration, a depth the register field cannot address
   if (DEPTH != (1 << REG_AW)) begin : g_depth_check
      $error("pm_regs: depth must match the register field");
   end

   logic [WORD_W-1:0] mem_ff [DEPTH];

   // ----------------------------------------------------------------
   // storage, no reset so it maps onto plain ram
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (pm.we)
         mem_ff[pm.waddr] <= pm.wdata;
   end

   // read ports hold their word until the next enabled read
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pm.rdata_a <= '0;
         pm.rdata_b <= '0;
      end else begin
         if (pm.re_a)
            pm.rdata_a <= mem_ff[pm.raddr_a];
         if (pm.re_b)
            pm.rdata_b <= mem_ff[pm.raddr_b];
      end
   end

endmodule

// ==== verif/add_sub_exec_asserts.sv ====
// port assertions for the add/subtract sequencer
// assumes a bind into add_sub_exec, one clock domain
`timescale 1ns/100ps
module add_sub_exec_asserts
   import add_sub_pkg::*;
(
   input wire logic              sys_clk,
   input wire logic              rst_n,
   input wire logic              start,
   input wire logic [7:0]        opcode,
   input wire logic [ADDR_W-1:0] hi_word_addr,
   input wire logic              mem_release,
   input wire logic              busy,
   input wire logic              done,
   input wire logic              core_req,
   input wire logic [ADDR_W-1:0] core_addr,
   input wire logic              data_wait,
   input wire logic [3:0]        cond_code,
   input wire logic              trap_req,
   input wire logic              long_clock_period
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // ------------------------------------------------------------
   // accepted starts, split by operand size
   // ------------------------------------------------------------
   logic go, go_w, go_d;
   assign go   = start && !busy && !data_wait;
   assign go_w = go && (opcode[6:0] == OPC_ADD_WORD ||
                        opcode[6:0] == OPC_SUB_WORD);
   assign go_d = go && (opcode[6:0] == OPC_ADD_DWORD ||
                        opcode[6:0] == OPC_SUB_DWORD);
   // phase order fixed by the cycle walk of each kind
   chk_word_seq: assert property (
      go_w |-> ##2 (long_clock_period && core_req) ##1 done)
      else $error("word phase timing wrong");
   chk_dword_seq: assert property (
      go_d |-> ##2 (long_clock_period && core_req) ##1 data_wait)
      else $error("dword phase timing wrong");
   chk_hi_addr: assert property (
      go_d |-> ##2 core_addr == $past(hi_word_addr, 2))
      else $error("high word address not requested");
   chk_cc_sign: assert property (
      !(cond_code[CC_POS_BIT] && cond_code[CC_NEG_BIT]))
      else $error("positive and negative both set");
   chk_trap_pulse: assert property (
      trap_req |=> !trap_req)
      else $error("trap request longer than a cycle");
   chk_trap_ovf: assert property (
      trap_req |-> cond_code[CC_OVF_BIT])
      else $error("trap without overflow flag");
   chk_wait_hold: assert property (
      data_wait && !mem_release |=> data_wait && !done)
      else $error("wait dropped without release");
   chk_wait_busy: assert property (
      data_wait |-> busy)
      else $error("wait while not busy");
   chk_long_busy: assert property (
      long_clock_period |-> busy)
      else $error("long period outside an op");
   cover property (go_w ##3 done);
   cover property (go_d ##3 data_wait);
   cover property (trap_req);
endmodule

bind add_sub_exec add_sub_exec_asserts chk (
   .sys_clk, .rst_n, .start, .opcode, .hi_word_addr, .mem_release, .busy,
   .done, .core_req, .core_addr, .data_wait, .cond_code, .trap_req,
   .long_clock_period
);

// ==== verif/core_mem_model.sv ====
// core memory stand-in answering each data wait with a release
// assumes the bench sets the returned word and the answer delay
`timescale 1ns/100ps
module core_mem_model (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        data_wait,
   input  wire logic [7:0]  delay,
   input  wire logic [31:0] hi_word,
   output logic             mem_release,
   output logic [31:0]      mem_data
);
   logic [7:0] wait_ff;
   // data only beside the release, a moving pattern otherwise
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_ff     <= 8'h00;
         mem_release <= 1'b0;
         mem_data    <= 32'h0;
      end else if (data_wait && !mem_release && wait_ff >= delay) begin
         wait_ff     <= 8'h00;
         mem_release <= 1'b1;
         mem_data    <= hi_word;
      end else begin
         wait_ff     <= (data_wait && !mem_release) ? wait_ff + 8'h01 : 8'h00;
         mem_release <= 1'b0;
         mem_data    <= ~mem_data;
      end
   end
endmodule

// ==== verif/testbench.sv ====
// self-checking bench for the add/subtract sequencer
// assumes the core memory model answers every data wait
`timescale 1ns/100ps
module testbench
   import add_sub_pkg::*;
;
   logic rst_n = 1'b0, start = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
   logic sys_clk, mem_release, busy, done, core_req, data_wait, trap_req;
   logic long_clock_period;
   logic [7:0]        opcode = 8'h0, delay = 8'h0, trap_vector;
   logic [REG_AW-1:0] reg_field = 4'h0;
   logic [WORD_W-1:0] eff_word = 32'h0, hi_word = 32'h0, bus_wdata = 32'h0;
   logic [WORD_W-1:0] mem_data, bus_rdata, sum_bus;
   logic [ADDR_W-1:0] hi_word_addr = 17'h0, core_addr;
   logic [ADDR_W-1:0] next_pc = 17'h00100;
   logic [BUS_AW-1:0] bus_addr = 5'h0;
   logic [3:0]        cond_code, last_cc;
   logic [31:0]       shadow [16];
   int                err_total = 0, total_checks = 0, traps = 0, cycles = 0;
   logic [7:0]  wop [5] = '{8'h30, 8'hb0, 8'h38, 8'hb8, 8'h38};
   logic [31:0] wrv [5] = '{32'h7fffffff, 32'hffffffff, 32'h5, 32'h0,
                            32'h80000000};
   logic [31:0] wew [5] = '{32'h1, 32'h1, 32'h5, 32'h1, 32'h1};
   logic [7:0]  dop [4] = '{8'h10, 8'h90, 8'h18, 8'h98};
   logic [63:0] dra [4] = '{64'h0_ffffffff, 64'h1, 64'h1_00000000,
                            64'h7fffffff_ffffffff};
   logic [63:0] ded [4] = '{64'h1, 64'hffffffff_ffffffff, 64'h1,
                            64'hffffffff_ffffffff};

   add_sub_exec dut (.sys_clk, .rst_n, .start, .opcode, .reg_field,
      .eff_word, .hi_word_addr, .next_pc, .mem_data, .mem_release,
      .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .busy, .done,
      .core_req, .core_addr, .data_wait, .sum_bus, .cond_code, .trap_req,
      .trap_vector, .long_clock_period);
   core_mem_model mem (.sys_clk, .rst_n, .data_wait, .delay, .hi_word,
      .mem_release, .mem_data);

   // ------------------------------------------------------------
   // clock, trap counting and hang limit
   // ------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (trap_req === 1'b1) traps++;
      if (cycles == 20000) begin
         err_total++;
         complete_run;
      end
   end

   // ------------------------------------------------------------
   // access tasks and the expected-result model
   // ------------------------------------------------------------
   task automatic complete_run;
      $display("checks %0d, mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   // land the edge's updates before looking or driving
   task automatic tick;
      @(posedge sys_clk);
      #1;
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wdata <= d;
      tick;
      bus_wr <= 1'b0;
      tick;
   endtask
   // read answer stands from the cycle after the strobe until the next read
   task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
      bus_rd <= 1'b1;
      bus_addr <= a;
      tick;
      bus_rd <= 1'b0;
      check(bus_rdata, exp);
      tick;
   endtask
   task automatic put(input logic [3:0] r, input logic [31:0] v);
      wr({1'b0, r}, v);
      shadow[r] = v;
   endtask
   // word operands sit in the upper half so one adder serves both
   function automatic logic [67:0] calc(input logic sb,
                                        input logic [63:0] a, d);
      logic [64:0] s;
      logic [63:0] dd;
      dd = sb ? ~d : d;
      s = {1'b0, a} + {1'b0, dd} + {64'h0, sb};
      return {s[64], (a[63] == dd[63]) && (s[63] != a[63]),
              !s[63] && (s[63:0] != 64'h0), s[63], s[63:0]};
   endfunction
   task automatic exec(input logic [7:0] op, input logic [3:0] r,
                       input logic [31:0] ew, input logic [31:0] hw,
                       input logic msk);
      logic        dw;
      logic        tr;
      logic [67:0] e;
      int          n;
      int          t0;
      dw = op[6:0] == OPC_ADD_DWORD || op[6:0] == OPC_SUB_DWORD;
      e = calc(op[3], dw ? {shadow[r], shadow[r | 4'h1]} : {shadow[r], 32'h0},
               dw ? {hw, ew} : {ew, 32'h0});
      tr = msk && e[66];
      hi_word <= hw;
      for (n = 0; busy !== 1'b0 && n < 100; n++) tick;
      t0 = traps;
      start <= 1'b1;
      opcode <= op;
      reg_field <= r;
      eff_word <= ew;
      hi_word_addr <= {13'h0, r};
      tick;
      start <= 1'b0;
      for (n = 0; done !== 1'b1 && n < 200; n++) tick;
      check(done, 1'b1);
      check(cond_code, e[67:64]);
      if (!tr) check(sum_bus, e[63:32]);
      last_cc = e[67:64];
      tick;
      check(64'(traps - t0), tr);
      if (!tr) shadow[r] = e[63:32];
      if (!tr && dw) shadow[r | 4'h1] = e[31:0];
      rdchk({1'b0, r}, shadow[r]);
      if (dw) rdchk({1'b0, r | 4'h1}, shadow[r | 4'h1]);
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      tick;
      rdchk(ADDR_STATUS, 32'h0);
      rdchk(ADDR_CONTROL, 32'h0);
      rdchk(5'h1f, 32'h0);
      check(trap_vector, TRAP_VECTOR);
      // every word encoding, mask clear so overflow only flags
      for (int i = 0; i < 5; i++) begin
         put(4'(i + 1), wrv[i]);
         exec(wop[i], 4'(i + 1), wew[i], 32'h0, 1'b0);
      end
      // even pairs only, memory answering slower each time
      for (int i = 0; i < 4; i++) begin
         put(4'(6 + 2 * i), dra[i][63:32]);
         put(4'(7 + 2 * i), dra[i][31:0]);
         delay <= 8'(3 * i);
         exec(dop[i], 4'(6+2*i), ded[i][31:0], ded[i][63:32], 1'b0);
      end
      // mask set: overflow traps and leaves registers alone
      wr(ADDR_CONTROL, 32'h1);
      rdchk(ADDR_CONTROL, 32'h1);
      put(4'd12, 32'h7fffffff);
      put(4'd13, 32'hffffffff);
      exec(8'h98, 4'd12, 32'hffffffff, 32'hffffffff, 1'b1);
      put(4'd1, 32'h7fffffff);
      exec(8'h30, 4'd1, 32'h1, 32'h0, 1'b1);
      rdchk(ADDR_STATUS, {25'h0, 1'b1, 2'b00, last_cc});
      wr(ADDR_STATUS, 32'h40);
      rdchk(ADDR_STATUS, {28'h0, last_cc});
      complete_run;
   end
endmodule
